// ---- rtl/mscl_defines.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef MSCL_DEFINES_SVH
`define MSCL_DEFINES_SVH
`define MSCL_OFF_CTRL 12'h000
`define MSCL_OFF_LOW_DATA 12'h004
`define MSCL_OFF_HIGH_DATA 12'h008
`define MSCL_OFF_STATUS 12'h00C
`define MSCL_OFF_MASK 12'h010
`define MSCL_OFF_RX_DATA 12'h014
`define MSCL_OFF_USER 12'h018
`define MSCL_CTRL_START 0
`define MSCL_CTRL_IRQSEL_LO 1
`define MSCL_CTRL_NLOW_LO 3
`define MSCL_CTRL_NHIGH_LO 8
`define MSCL_CTRL_RST 32'h0000_1000
`define MSCL_ST_FRAME 0
`define MSCL_ST_RXDONE 1
`define MSCL_ST_BUSY 2
`define MSCL_IRQSEL_LAST 2'h1
`define MSCL_IRQSEL_FIRST 2'h2
`define MSCL_USER_BITS 5
`define MSCL_DS_DIV 4'h4
`define MSCL_US_DIV 4'h8
`define MSCL_US_BITS 4'hA
`endif

// ---- rtl/mscl_pkg.sv ----
// Types shared by the serial channel link
package mscl_pkg;
    typedef enum logic [1:0] {
        MSCL_DS_IDLE = 2'b00,
        MSCL_DS_LOW = 2'b01,
        MSCL_DS_HIGH = 2'b10
    } mscl_ds_state_t;
    typedef enum logic [1:0] {
        MSCL_US_IDLE = 2'b00,
        MSCL_US_START = 2'b01,
        MSCL_US_DATA = 2'b10,
        MSCL_US_LAST = 2'b11
    } mscl_us_state_t;
endpackage

// ---- rtl/mscl_sync.sv ----
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module mscl_sync (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic async_in,
    output logic level_out
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
            s3_r <= 1'b1;
            level_out <= 1'b1;
        end else begin
            s1_r <= async_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                level_out <= s3_r;
            end
        end
    end
endmodule

// ---- rtl/mscl_top.sv ----
// Serial channel link: downstream shifter, upstream receiver, AXI4-Lite registers
//
// Contract
// R1 - Upstream receiver accepts back-to-back frames without idle gap.
// R2 - In last frame state, a falling edge starts next frame, else idle.
// R3 - From idle, next falling edge is taken as start bit.
// R4 - Upstream input synchronised and edge-detected on module clock.
// R5 - Select 10B raises frame interrupt on first shifted data bit.
// R6 - Select 01B raises frame interrupt with last shifted data bit.
// R7 - Frame has low and high part; low count 0 drops low part.
// R8 - First-bit interrupt also fires when first bit is high part.
// R9 - Low-part bit count is five bits wide.
// R10 - Each part drives its own chip select, high only when sending.
// R11 - User register bits 4..0 written by word, low half or low byte.
// R12 - Stores to upper lanes leave user register bits unchanged.
// R13 - Transmitter should add a third stop bit for a gap.
// R14 - Synchronised transmitter derives rate from running downstream clock.
`timescale 1ns/1ns
`include "mscl_defines.svh"
module mscl_top
    import mscl_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic downstream_clock_out,
    output logic downstream_data_out,
    output logic chip_select_low,
    output logic chip_select_high,
    input wire logic upstream_serial_input,
    output logic irq
);
    // ----------------------------------------------------------------
    // Registers and bus state
    // ----------------------------------------------------------------
    logic [31:0] ctrl_r;
    logic [31:0] low_data_r;
    logic [31:0] high_data_r;
    logic [2:0] status_r;
    logic [2:0] mask_r;
    logic [7:0] rx_data_r;
    logic [4:0] user_control_register_r;
    logic [11:0] waddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic frame_evt;
    logic rx_evt;

    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
            input logic [31:0] new_v, input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    wire do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    wire wr_ctrl = do_write && (waddr_r == `MSCL_OFF_CTRL);
    wire wr_low = do_write && (waddr_r == `MSCL_OFF_LOW_DATA);
    wire wr_high = do_write && (waddr_r == `MSCL_OFF_HIGH_DATA);
    wire wr_status = do_write && (waddr_r == `MSCL_OFF_STATUS);
    wire wr_mask = do_write && (waddr_r == `MSCL_OFF_MASK);
    wire wr_user = do_write && (waddr_r == `MSCL_OFF_USER) && wstrb_r[0];
    wire w_mapped = (waddr_r == `MSCL_OFF_CTRL) || (waddr_r == `MSCL_OFF_LOW_DATA) ||
        (waddr_r == `MSCL_OFF_HIGH_DATA) || (waddr_r == `MSCL_OFF_STATUS) ||
        (waddr_r == `MSCL_OFF_MASK) || (waddr_r == `MSCL_OFF_USER);
    wire [31:0] ctrl_nxt = lane_merge(ctrl_r, wdata_r, wstrb_r);
    wire [1:0] frame_irq_select = ctrl_r[`MSCL_CTRL_IRQSEL_LO +: 2];
    wire [4:0] low_part_bit_count = ctrl_r[`MSCL_CTRL_NLOW_LO +: 5]; // [R9]
    wire [4:0] high_part_bit_count = ctrl_r[`MSCL_CTRL_NHIGH_LO +: 5];
    wire [2:0] status_set = {1'b0, rx_evt, frame_evt};
    wire [2:0] status_clr = wr_status && wstrb_r[0] ? wdata_r[2:0] : 3'h0;
    mscl_ds_state_t ds_state_r;
    logic [3:0] ds_div_r;
    logic [4:0] ds_cnt_r;
    logic [31:0] ds_shift_r;
    logic ds_first_r;
    wire ds_busy = (ds_state_r != MSCL_DS_IDLE);
    wire ds_start = ctrl_r[`MSCL_CTRL_START] && !ds_busy && !wr_ctrl;
    wire ds_tick = ds_busy && (ds_div_r == `MSCL_DS_DIV - 4'h1);
    wire ds_part_end = ds_tick && (ds_cnt_r == 5'h00);
    wire ds_frame_end = ds_part_end && (ds_state_r == MSCL_DS_HIGH);
    wire ds_low_used = (low_part_bit_count != 5'h00); // [R7]

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            waddr_r <= 12'h000;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                waddr_r <= {s_axi_awaddr[11:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= w_mapped ? 2'b00 : 2'b10;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= `MSCL_CTRL_RST;
            low_data_r <= 32'h0000_0000;
            high_data_r <= 32'h0000_0000;
            mask_r <= 3'h0;
            user_control_register_r <= 5'h00;
            status_r <= 3'h0;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= ctrl_nxt;
            end else if (ds_start) begin
                ctrl_r[`MSCL_CTRL_START] <= 1'b0;
            end
            if (wr_low) begin
                low_data_r <= lane_merge(low_data_r, wdata_r, wstrb_r);
            end
            if (wr_high) begin
                high_data_r <= lane_merge(high_data_r, wdata_r, wstrb_r);
            end
            if (wr_mask && wstrb_r[0]) begin
                mask_r <= wdata_r[2:0];
            end
            if (wr_user) begin
                // Only the lowest lane holds writable bits; others are ignored
                user_control_register_r <= wdata_r[`MSCL_USER_BITS-1:0]; // [R11] [R12]
            end
            status_r <= (status_r & ~status_clr) | status_set;
        end
    end

    logic [31:0] rd_mux;
    always_comb begin
        unique case (s_axi_araddr & 12'hFFC)
            `MSCL_OFF_CTRL: rd_mux = ctrl_r;
            `MSCL_OFF_LOW_DATA: rd_mux = low_data_r;
            `MSCL_OFF_HIGH_DATA: rd_mux = high_data_r;
            `MSCL_OFF_STATUS: rd_mux = {29'h0, ds_busy, status_r[1:0]};
            `MSCL_OFF_MASK: rd_mux = {29'h0, mask_r};
            `MSCL_OFF_RX_DATA: rd_mux = {24'h0, rx_data_r};
            `MSCL_OFF_USER: rd_mux = {27'h0, user_control_register_r};
            default: rd_mux = 32'h0000_0000;
        endcase
    end
    wire rd_mapped = (s_axi_araddr[11:2] <= 10'h006);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
            irq <= 1'b0;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_mapped ? 2'b00 : 2'b10;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            irq <= |(status_r & mask_r);
        end
    end

    // ----------------------------------------------------------------
    // Downstream channel
    // ----------------------------------------------------------------
    // First data bit out, whichever part carries it, or last data bit of the frame
    assign frame_evt = ((frame_irq_select == `MSCL_IRQSEL_FIRST) && ds_first_r && ds_tick) || // [R5] [R8]
        ((frame_irq_select == `MSCL_IRQSEL_LAST) && ds_frame_end); // [R6]

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ds_state_r <= MSCL_DS_IDLE;
            ds_div_r <= 4'h0;
            ds_cnt_r <= 5'h00;
            ds_shift_r <= 32'h0000_0000;
            ds_first_r <= 1'b0;
            downstream_clock_out <= 1'b0;
            downstream_data_out <= 1'b0;
            chip_select_low <= 1'b0;
            chip_select_high <= 1'b0;
        end else begin
            ds_div_r <= (!ds_busy || ds_tick) ? 4'h0 : ds_div_r + 4'h1;
            // Rises mid-bit, falls as the next bit is placed
            downstream_clock_out <= ds_busy && !ds_tick &&
                (ds_div_r >= (`MSCL_DS_DIV >> 1) - 4'h1);
            if (ds_start) begin
                ds_first_r <= 1'b1;
                if (ds_low_used) begin // [R7]
                    ds_state_r <= MSCL_DS_LOW;
                    ds_cnt_r <= low_part_bit_count - 5'h01;
                    downstream_data_out <= low_data_r[0];
                    ds_shift_r <= {1'b0, low_data_r[31:1]};
                    chip_select_low <= 1'b1; // [R10]
                end else begin
                    ds_state_r <= MSCL_DS_HIGH;
                    ds_cnt_r <= high_part_bit_count - 5'h01;
                    downstream_data_out <= high_data_r[0];
                    ds_shift_r <= {1'b0, high_data_r[31:1]};
                    chip_select_high <= 1'b1; // [R10]
                end
            end else if (ds_tick) begin
                ds_first_r <= 1'b0;
                downstream_data_out <= ds_shift_r[0];
                ds_shift_r <= {1'b0, ds_shift_r[31:1]};
                ds_cnt_r <= ds_cnt_r - 5'h01;
                if (ds_part_end && ds_state_r == MSCL_DS_LOW) begin
                    ds_state_r <= MSCL_DS_HIGH;
                    ds_cnt_r <= high_part_bit_count - 5'h01;
                    downstream_data_out <= high_data_r[0];
                    ds_shift_r <= {1'b0, high_data_r[31:1]};
                    chip_select_low <= 1'b0;
                    chip_select_high <= 1'b1; // [R10]
                end else if (ds_frame_end) begin
                    ds_state_r <= MSCL_DS_IDLE;
                    chip_select_high <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Upstream receiver
    // ----------------------------------------------------------------
    logic us_level;
    logic us_prev_r;
    mscl_us_state_t us_state_r;
    logic [3:0] us_div_r;
    logic [3:0] us_bit_r;
    logic [7:0] us_shift_r;

    mscl_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(upstream_serial_input),
        .level_out(us_level)
    ); // [R4]

    wire us_fall = us_prev_r && !us_level; // [R4]
    wire us_mid = (us_div_r == (`MSCL_US_DIV >> 1) - 4'h1);
    wire us_wrap = (us_div_r == `MSCL_US_DIV - 4'h1);
    assign rx_evt = (us_state_r == MSCL_US_DATA) && us_mid && (us_bit_r == 4'h9) && us_level;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            us_prev_r <= 1'b1;
            us_state_r <= MSCL_US_IDLE;
            us_div_r <= 4'h0;
            us_bit_r <= 4'h0;
            us_shift_r <= 8'h00;
            rx_data_r <= 8'h00;
        end else begin
            us_prev_r <= us_level;
            us_div_r <= us_wrap ? 4'h0 : us_div_r + 4'h1;
            unique case (us_state_r)
                MSCL_US_IDLE: begin
                    if (us_fall) begin // [R3]
                        us_state_r <= MSCL_US_START;
                        us_div_r <= 4'h0;
                    end
                end
                MSCL_US_START: begin
                    if (us_mid) begin
                        us_state_r <= us_level ? MSCL_US_IDLE : MSCL_US_DATA;
                        us_bit_r <= 4'h1;
                    end
                end
                MSCL_US_DATA: begin
                    if (us_mid) begin
                        us_bit_r <= us_bit_r + 4'h1;
                        if (us_bit_r <= 4'h8) begin
                            us_shift_r <= {us_level, us_shift_r[7:1]};
                        end
                        if (us_bit_r == 4'h9) begin
                            rx_data_r <= us_shift_r;
                            us_state_r <= MSCL_US_LAST;
                        end
                    end
                end
                MSCL_US_LAST: begin
                    // Watch for a new start bit until stop-bit end
                    if (us_fall) begin // [R1] [R2]
                        us_state_r <= MSCL_US_START;
                        us_div_r <= 4'h0;
                    end else if (us_wrap) begin
                        us_state_r <= MSCL_US_IDLE; // [R2]
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_last_fall;
        (us_state_r == MSCL_US_LAST) && us_fall;
    endsequence
    a_back_to_back: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
        s_last_fall |=> us_state_r == MSCL_US_START) else $error("back-to-back frame lost");
    a_last_to_idle: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
        (us_state_r == MSCL_US_LAST) && !us_fall && us_wrap |=> us_state_r == MSCL_US_IDLE)
        else $error("last state not returning to idle");
    a_idle_start: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
        (us_state_r == MSCL_US_IDLE) && us_fall |=> us_state_r == MSCL_US_START)
        else $error("start edge missed from idle");
    a_edge_sync: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
        us_fall |-> $past(us_level) && !us_level) else $error("edge not on synced level");
    a_first_irq: assert property (@(posedge aclk) disable iff (!aresetn) // [R5]
        ds_start && frame_irq_select == `MSCL_IRQSEL_FIRST && !wr_status
        |-> ##[1:8] status_r[`MSCL_ST_FRAME]) else $error("first-bit irq missing");
    a_last_irq: assert property (@(posedge aclk) disable iff (!aresetn) // [R6]
        ds_frame_end && frame_irq_select == `MSCL_IRQSEL_LAST |=> status_r[`MSCL_ST_FRAME])
        else $error("last-bit irq missing");
    a_low_skip: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
        ds_start && !ds_low_used |=> ds_state_r == MSCL_DS_HIGH && !chip_select_low)
        else $error("low part not skipped");
    a_high_first: assert property (@(posedge aclk) disable iff (!aresetn) // [R8]
        ds_start && !ds_low_used && frame_irq_select == `MSCL_IRQSEL_FIRST
        |-> ##[1:8] frame_evt) else $error("high first irq");
    a_cs_part: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
        chip_select_high |-> ds_state_r == MSCL_DS_HIGH) else $error("high select stray");
    a_user_keep: assert property (@(posedge aclk) disable iff (!aresetn) // [R12]
        do_write && waddr_r == `MSCL_OFF_USER && !wstrb_r[0]
        |=> $stable(user_control_register_r)) else $error("user bits disturbed");
endmodule

// ---- verification/mscl_asic_model.sv ----
// Behavioural far-side transmitter driving the upstream serial line
`timescale 1ns/1ns
module mscl_asic_model (
    output logic upstream_line
);
    // Free-running bit rate, not locked to the downstream clock
    localparam int BIT_NS = 320;
    initial upstream_line = 1'b1;
    // ------------------------------
    // Frame sender, LSB first, idle high
    // ------------------------------
    task automatic send(input logic [7:0] b, input int stops);
        int i;
        upstream_line = 1'b0;
        #BIT_NS;
        for (i = 0; i < 8; i++) begin
            upstream_line = b[i];
            #BIT_NS;
        end
        upstream_line = 1'b1;
        #(BIT_NS * stops);
    endtask
endmodule

// ---- verification/mscl_top_tb.sv ----
// Self-checking bench for the serial channel link
`timescale 1ns/1ns
`include "mscl_defines.svh"
module mscl_top_tb;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000, rdata, rd_data, v;
    logic [3:0] wstrb = 4'h0;
    logic [1:0] bresp, rresp;
    logic dclk, dout, cs_lo, cs_hi, irq, sdi, dclk_q = 1'b0;
    logic [31:0] st = 32'h0000_8b83;
    logic [34:0] q_rd[$], en;
    logic [2:0] q_ds[$], de;
    logic [7:0] bt[6];
    int n_fail = 0, checked = 0, cyc = 0, k;
    always #20 aclk = ~aclk;
    mscl_top u_mscl_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .downstream_clock_out(dclk), .downstream_data_out(dout),
        .chip_select_low(cs_lo), .chip_select_high(cs_hi), .upstream_serial_input(sdi),
        .irq(irq));
    mscl_asic_model u_mscl_asic_model (.upstream_line(sdi));
    // ------------------------------
    // Helpers
    // ------------------------------
    function automatic logic [31:0] xs();
        st = st ^ (st << 13);
        st = st ^ (st >> 17);
        st = st ^ (st << 5);
        return st;
    endfunction
    task automatic cmp_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmp_bit(input string nm, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic complete_run();
        $display("counts checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                bready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic c, input logic [1:0] rs,
                      input logic [31:0] e);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        q_rd.push_back({c, rs, e});
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                rd_data = rdata;
                rready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic rx_get(input logic [7:0] b);
        int t;
        for (t = 0; t < 300; t++) begin
            rd(`MSCL_OFF_STATUS, 1'b0, 2'b00, 32'h0000_0000);
            if (rd_data[`MSCL_ST_RXDONE] === 1'b1) break;
        end
        cmp_bit("rx done", 1'b1, rd_data[`MSCL_ST_RXDONE]);
        rd(`MSCL_OFF_RX_DATA, 1'b1, 2'b00, {24'h00_0000, b});
        wr(`MSCL_OFF_STATUS, 32'h0000_0002, 4'hf);
    endtask
    task automatic ds_run(input logic [1:0] sel, input logic [4:0] nl, input logic [4:0] nh,
                          input logic m);
        logic [31:0] lo, hi;
        int i;
        lo = xs();
        hi = xs();
        wr(`MSCL_OFF_LOW_DATA, lo, 4'hf);
        wr(`MSCL_OFF_HIGH_DATA, hi, 4'hf);
        wr(`MSCL_OFF_MASK, {31'h0, m}, 4'hf);
        for (i = 0; i < nl; i++) q_ds.push_back({1'b1, 1'b0, lo[i]});
        for (i = 0; i < nh; i++) q_ds.push_back({1'b0, 1'b1, hi[i]});
        wr(`MSCL_OFF_CTRL, {19'h0, nh, nl, sel, 1'b1}, 4'hf);
        tick(20);
        rd(`MSCL_OFF_STATUS, 1'b1, 2'b00, {29'h0, 2'b10, sel == `MSCL_IRQSEL_FIRST});
        tick((int'(nl) + int'(nh)) * 4 + 8);
        rd(`MSCL_OFF_STATUS, 1'b1, 2'b00, 32'h0000_0001);
        cmp_word("bits left", 32'h0000_0000, 32'(q_ds.size()));
        cmp_bit("irq", m, irq);
        wr(`MSCL_OFF_STATUS, 32'h0000_0001, 4'hf);
        rd(`MSCL_OFF_STATUS, 1'b1, 2'b00, 32'h0000_0000);
        cmp_bit("irq cleared", 1'b0, irq);
        $display("test downstream frame done");
    endtask
    // ------------------------------
    // Result watchers and timeout
    // ------------------------------
    always @(posedge aclk) begin
        if (rvalid && rready && q_rd.size() > 0) begin
            en = q_rd.pop_front();
            if (en[34]) begin
                cmp_word("read resp", {30'h0, en[33:32]}, {30'h0, rresp});
                cmp_word("read data", en[31:0], rdata);
            end
        end
    end
    always @(posedge aclk) begin
        dclk_q <= dclk;
        if (dclk === 1'b1 && dclk_q === 1'b0) begin
            if (q_ds.size() == 0) begin
                cmp_bit("unexpected bit", 1'b0, 1'b1);
            end else begin
                de = q_ds.pop_front();
                cmp_word("link bit", {29'h0, de}, {29'h0, cs_lo, cs_hi, dout});
            end
        end
    end
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            complete_run();
        end
    end
    // ------------------------------
    // Main sequence
    // ------------------------------
    initial begin
        tick(10);
        aresetn <= 1'b1;
        rd(`MSCL_OFF_CTRL, 1'b1, 2'b00, `MSCL_CTRL_RST);
        rd(`MSCL_OFF_STATUS, 1'b1, 2'b00, 32'h0000_0000);
        rd(12'h100, 1'b1, 2'b10, 32'h0000_0000);
        $display("test registers done");
        ds_run(`MSCL_IRQSEL_FIRST, 5'd0, 5'd12, 1'b1);
        ds_run(`MSCL_IRQSEL_LAST, 5'd1, 5'd12, 1'b1);
        ds_run(`MSCL_IRQSEL_FIRST, 5'd31, 5'd9, 1'b0);
        ds_run(`MSCL_IRQSEL_LAST, 5'd3, 5'd31, 1'b1);
        v = xs();
        wr(`MSCL_OFF_USER, v, 4'hf);
        rd(`MSCL_OFF_USER, 1'b1, 2'b00, {27'h0, v[4:0]});
        for (k = 1; k < 4; k++) begin
            wr(`MSCL_OFF_USER, ~v, 4'(1 << k));
            rd(`MSCL_OFF_USER, 1'b1, 2'b00, {27'h0, v[4:0]});
        end
        wr(`MSCL_OFF_USER, ~v, 4'hc);
        rd(`MSCL_OFF_USER, 1'b1, 2'b00, {27'h0, v[4:0]});
        wr(`MSCL_OFF_USER, ~v, 4'h1);
        rd(`MSCL_OFF_USER, 1'b1, 2'b00, {27'h0, ~v[4:0]});
        wr(`MSCL_OFF_USER, v, 4'h3);
        rd(`MSCL_OFF_USER, 1'b1, 2'b00, {27'h0, v[4:0]});
        $display("test user register done");
        for (k = 0; k < 6; k++) begin
            v = xs();
            bt[k] = v[7:0];
        end
        fork
            begin
                #13;
                u_mscl_asic_model.send(bt[0], 1);
                u_mscl_asic_model.send(bt[1], 1);
                u_mscl_asic_model.send(bt[2], 1);
                u_mscl_asic_model.send(bt[3], 3);
                u_mscl_asic_model.send(bt[4], 3);
            end
        join_none
        for (k = 0; k < 5; k++) rx_get(bt[k]);
        tick(100);
        fork
            begin
                #13;
                u_mscl_asic_model.send(bt[5], 1);
            end
        join_none
        rx_get(bt[5]);
        $display("test upstream frames done");
        complete_run();
    end
endmodule
